// ==== inc/opr_map.svh ====
// register offsets, command codes, reset values and timing counts for the panel sequencer
`ifndef OPR_MAP_SVH
`define OPR_MAP_SVH
`define OPR_CLK_HZ 100000000
`define OPR_SETTLE_MS 100
`define OPR_SETTLE_CYC ((`OPR_CLK_HZ / 1000) * `OPR_SETTLE_MS)
`define OPR_ADR_CTRL 4'h0
`define OPR_ADR_STAT 4'h4
`define OPR_ADR_CMD 4'h8
`define OPR_ADR_DEV 4'hC
`define OPR_CMD_DISP_OFF 8'hAE
`define OPR_CMD_DISP_ON 8'hAF
`define OPR_CMD_PUMP 8'h8D
`define OPR_ARG_PUMP_ON 8'h14
`define OPR_ARG_PUMP_OFF 8'h10
`define OPR_CMD_CONTRAST 8'h81
`define OPR_CMD_RESUME 8'hA4
`define OPR_CMD_ALL_ON 8'hA5
`define OPR_CMD_NORMAL 8'hA6
`define OPR_CMD_INVERSE 8'hA7
`define OPR_CMD_SEG_NORM 8'hA0
`define OPR_CMD_SEG_REMAP 8'hA1
`define OPR_CMD_SCAN_NORM 8'hC0
`define OPR_CMD_SCAN_REV 8'hC8
`define OPR_CMD_OSC 8'hD5
`define OPR_CMD_PRECHG 8'hD9
`define OPR_ARG_OSC 8'h80
`define OPR_ARG_PRECHG 8'h21
`define OPR_CMD_COLHI 8'h12
`define OPR_CMD_START 8'h40
`define OPR_CMD_PAGE 8'hB0
`define OPR_RST_CONTRAST 8'h7F
`define OPR_RST_ZERO 8'h00
`define OPR_CTRL_UP 0
`define OPR_CTRL_DOWN 1
`define OPR_CTRL_PUMP 2
`define OPR_CTRL_RESET 3
`endif

// ==== inc/opr_pkg.sv ====
// types for the two ends of the panel sequencer: host states and panel decoder states
package opr_pkg;
	typedef enum logic [9:0] {
		OPR_IDLE = 10'h001,
		OPR_SEND = 10'h002,
		OPR_STROBE = 10'h004,
		OPR_RELEASE = 10'h008,
		OPR_PANEL_ON = 10'h010,
		OPR_WAIT_ON = 10'h020,
		OPR_PANEL_OFF = 10'h040,
		OPR_WAIT_OFF = 10'h080,
		OPR_LOGIC_OFF = 10'h100,
		OPR_NEXT = 10'h200
	} opr_state_t;
	typedef enum logic [2:0] {
		OPR_DEC_NONE = 3'h1,
		OPR_DEC_ARG = 3'h2,
		OPR_DEC_DONE = 3'h4
	} opr_dec_t;
endpackage

// ==== inc/opr_link_if.sv ====
// parallel write port and supply switches between host and panel
`timescale 1ns/1ps
interface opr_link_if;
	logic panel_reset_n;
	logic cmd_data_select;
	logic cs_n;
	logic wr_n;
	logic [7:0] data;
	logic logic_supply_en;
	logic panel_supply_en;
	modport host (output panel_reset_n, output cmd_data_select, output cs_n, output wr_n, output data,
		output logic_supply_en, output panel_supply_en);
	modport panel (input panel_reset_n, input cmd_data_select, input cs_n, input wr_n, input data,
		input logic_supply_en, input panel_supply_en);
endinterface

// ==== verilog/opr_byte_rx.sv ====
// latches one byte per write strobe rising edge and flags command or data
`timescale 1ns/1ps
`include "opr_map.svh"
module opr_byte_rx (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic cs_n_in,
	input wire logic wr_n_in,
	input wire logic cmd_data_select_in,
	input wire logic [7:0] data_in,
	output logic valid_out,
	output logic is_data_out,
	output logic [7:0] byte_out
);
	logic wr_prev_r, wr_prev_nxt;
	logic valid_r, valid_nxt;
	logic is_data_r, is_data_nxt;
	logic [7:0] byte_r, byte_nxt;
	always_comb begin
		wr_prev_nxt = wr_n_in;
		valid_nxt = 1'b0;
		is_data_nxt = is_data_r;
		byte_nxt = byte_r;
		if (!cs_n_in && !wr_prev_r && wr_n_in) begin
			valid_nxt = 1'b1;
			is_data_nxt = cmd_data_select_in;
			byte_nxt = data_in;
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			wr_prev_r <= 1'b1;
			valid_r <= 1'b0;
			is_data_r <= 1'b0;
			byte_r <= `OPR_RST_ZERO;
		end else begin
			wr_prev_r <= wr_prev_nxt;
			valid_r <= valid_nxt;
			is_data_r <= is_data_nxt;
			byte_r <= byte_nxt;
		end
	end
	assign valid_out = valid_r;
	assign is_data_out = is_data_r;
	assign byte_out = byte_r;
endmodule

// ==== verilog/opr_panel.sv ====
// panel end: reset state and command decoding of the display module
`timescale 1ns/1ps
`include "opr_map.svh"
module opr_panel (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	opr_link_if.panel link,
	output logic display_on_out,
	output logic pump_on_out,
	output logic [7:0] contrast_out,
	output logic seg_remap_out,
	output logic scan_rev_out,
	output logic all_on_out,
	output logic [7:0] column_out,
	output logic [5:0] start_line_out,
	output logic [2:0] page_out,
	output logic mode_128x64_out,
	output logic [7:0] osc_out,
	output logic [7:0] precharge_out,
	output logic [7:0] data_count_out
);
	logic rst_n;
	logic rx_valid, rx_is_data;
	logic [7:0] rx_byte;
	opr_pkg::opr_dec_t dec_r, dec_nxt;
	logic [7:0] pend_r, pend_nxt;
	logic disp_r, disp_nxt, pump_r, pump_nxt, seg_r, seg_nxt, scan_r, scan_nxt, all_r, all_nxt;
	logic [7:0] con_r, con_nxt, col_r, col_nxt, osc_r, osc_nxt, pre_r, pre_nxt, cnt_r, cnt_nxt;
	logic [5:0] start_r, start_nxt;
	logic [2:0] page_r, page_nxt;
	logic mode_r, mode_nxt;
	// a board reset, the panel reset pin or a dropped logic supply clears the shift stage
	assign rst_n = reset_n_in & link.panel_reset_n & link.logic_supply_en;
	opr_byte_rx u_rx (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(rst_n),
		.cs_n_in(link.cs_n),
		.wr_n_in(link.wr_n),
		.cmd_data_select_in(link.cmd_data_select),
		.data_in(link.data),
		.valid_out(rx_valid),
		.is_data_out(rx_is_data),
		.byte_out(rx_byte)
	);
	always_comb begin
		dec_nxt = dec_r;
		pend_nxt = pend_r;
		disp_nxt = disp_r;
		pump_nxt = pump_r;
		seg_nxt = seg_r;
		scan_nxt = scan_r;
		all_nxt = all_r;
		con_nxt = con_r;
		col_nxt = col_r;
		osc_nxt = osc_r;
		pre_nxt = pre_r;
		cnt_nxt = cnt_r;
		start_nxt = start_r;
		page_nxt = page_r;
		mode_nxt = mode_r;
		if (rx_valid && rx_is_data) begin
			cnt_nxt = cnt_r + 8'h01;
			col_nxt = col_r + 8'h01;
		end else if (rx_valid && dec_r == opr_pkg::OPR_DEC_ARG) begin
			dec_nxt = opr_pkg::OPR_DEC_DONE;
			case (pend_r)
				`OPR_CMD_PUMP: begin
					if (rx_byte == `OPR_ARG_PUMP_ON) pump_nxt = 1'b1;
					else if (rx_byte == `OPR_ARG_PUMP_OFF) pump_nxt = 1'b0;
				end
				`OPR_CMD_CONTRAST: con_nxt = rx_byte;
				`OPR_CMD_OSC: osc_nxt = rx_byte;
				`OPR_CMD_PRECHG: pre_nxt = rx_byte;
				default: mode_nxt = 1'b0;
			endcase
		end else if (rx_valid) begin
			dec_nxt = opr_pkg::OPR_DEC_NONE;
			case (rx_byte)
				`OPR_CMD_DISP_OFF: disp_nxt = 1'b0;
				`OPR_CMD_DISP_ON: disp_nxt = 1'b1;
				`OPR_CMD_RESUME: all_nxt = 1'b0;
				`OPR_CMD_ALL_ON: all_nxt = 1'b1;
				// normal or inverse video take no argument, so the next byte stays a command
				`OPR_CMD_NORMAL, `OPR_CMD_INVERSE: dec_nxt = opr_pkg::OPR_DEC_NONE;
				`OPR_CMD_SEG_NORM: seg_nxt = 1'b0;
				`OPR_CMD_SEG_REMAP: seg_nxt = 1'b1;
				`OPR_CMD_SCAN_NORM: scan_nxt = 1'b0;
				`OPR_CMD_SCAN_REV: scan_nxt = 1'b1;
				default: begin
					if (rx_byte[7:4] == 4'h0) col_nxt = {col_r[7:4], rx_byte[3:0]};
					else if (rx_byte[7:4] == 4'h1) col_nxt = {rx_byte[3:0], col_r[3:0]};
					else if (rx_byte[7:6] == 2'h1) start_nxt = rx_byte[5:0];
					else if (rx_byte[7:3] == 5'h16) page_nxt = rx_byte[2:0];
					else begin
						// any other code is taken as taking one argument byte
						dec_nxt = opr_pkg::OPR_DEC_ARG;
						pend_nxt = rx_byte;
					end
				end
			endcase
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n) begin
			dec_r <= opr_pkg::OPR_DEC_NONE;
			pend_r <= `OPR_RST_ZERO;
			disp_r <= 1'b0;
			mode_r <= 1'b1;
			seg_r <= 1'b0;
			scan_r <= 1'b0;
			start_r <= 6'h00;
			col_r <= `OPR_RST_ZERO;
			con_r <= `OPR_RST_CONTRAST;
			all_r <= 1'b0;
			pump_r <= 1'b0;
			osc_r <= `OPR_RST_ZERO;
			pre_r <= `OPR_RST_ZERO;
			cnt_r <= `OPR_RST_ZERO;
			page_r <= 3'h0;
		end else begin
			dec_r <= dec_nxt;
			pend_r <= pend_nxt;
			disp_r <= disp_nxt;
			mode_r <= mode_nxt;
			seg_r <= seg_nxt;
			scan_r <= scan_nxt;
			start_r <= start_nxt;
			col_r <= col_nxt;
			con_r <= con_nxt;
			all_r <= all_nxt;
			pump_r <= pump_nxt;
			osc_r <= osc_nxt;
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
			page_r <= page_nxt;
		end
	end
	assign display_on_out = disp_r;
	assign pump_on_out = pump_r;
	assign contrast_out = con_r;
	assign seg_remap_out = seg_r;
	assign scan_rev_out = scan_r;
	assign all_on_out = all_r;
	assign column_out = col_r;
	assign start_line_out = start_r;
	assign page_out = page_r;
	assign mode_128x64_out = mode_r;
	assign osc_out = osc_r;
	assign precharge_out = pre_r;
	assign data_count_out = cnt_r;
endmodule

// ==== verilog/opr_host.sv ====
// host end: wishbone-driven power sequencing and init command stream
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "opr_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Operation
// - wait 100 ms before display on
// - logic, off, init, clear, panel, on
// - off, drop panel, wait, drop logic
// - logic supply never off before panel
// - reset restores normal column/row mapping
// - reset clears serial shift stage
// - reset zeroes start line, column, scan
// - reset loads contrast 7Fh
// - reset resumes normal RAM display
// - 8D with 14 on, 10 off
// - oscillator 80 then precharge 21
// - column 00/12, start 40, page B0
// - reapply reset after noise corruption
module opr_host #(
	parameter int unsigned SETTLE_CYC = `OPR_SETTLE_CYC
) (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [3:0] wb_sel_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	opr_link_if.host link
);
	localparam int ROM_LEN = 28;
	localparam int CLEAR_LEN = 48;
	// init stream; flag bit 8 marks data, bit 9 marks clear-screen repeat
	function automatic logic [9:0] rom(input logic [5:0] i, input logic pump);
		case (i)
			6'd0: rom = {2'b00, `OPR_CMD_DISP_OFF};
			6'd1: rom = 10'h000;
			6'd2: rom = {2'b00, `OPR_CMD_COLHI};
			6'd3: rom = {2'b00, `OPR_CMD_START};
			6'd4: rom = {2'b00, `OPR_CMD_PAGE};
			6'd5: rom = {2'b00, `OPR_CMD_CONTRAST};
			6'd6: rom = 10'h0FF;
			6'd7: rom = {2'b00, `OPR_CMD_SEG_REMAP};
			6'd8: rom = 10'h0A6;
			6'd9: rom = 10'h0A8;
			6'd10: rom = 10'h02F;
			6'd11: rom = {2'b00, `OPR_CMD_SCAN_REV};
			6'd12: rom = 10'h0D3;
			6'd13: rom = 10'h000;
			6'd14: rom = {2'b00, `OPR_CMD_OSC};
			6'd15: rom = {2'b00, `OPR_ARG_OSC};
			6'd16: rom = {2'b00, `OPR_CMD_PRECHG};
			6'd17: rom = {2'b00, `OPR_ARG_PRECHG};
			6'd18: rom = 10'h0DA;
			6'd19: rom = 10'h012;
			6'd20: rom = 10'h0DB;
			6'd21: rom = 10'h040;
			6'd22: rom = {2'b00, `OPR_CMD_PUMP};
			6'd23: rom = {2'b00, (pump ? `OPR_ARG_PUMP_ON : `OPR_ARG_PUMP_OFF)};
			6'd24: rom = {2'b00, `OPR_CMD_PAGE};
			6'd25: rom = 10'h000;
			6'd26: rom = 10'h010;
			default: rom = 10'h300; // clear-screen data burst
		endcase
	endfunction
	opr_pkg::opr_state_t st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [5:0] idx_r, idx_nxt;
	logic [5:0] rep_r, rep_nxt;
	logic [9:0] cur_r, cur_nxt;
	logic going_up_r, going_up_nxt;
	logic pump_r, pump_nxt, rst_cmd_r, rst_cmd_nxt;
	logic logic_en_r, logic_en_nxt, panel_en_r, panel_en_nxt;
	logic dcs_r, dcs_nxt, cs_n_r, cs_n_nxt, wr_n_r, wr_n_nxt;
	logic [7:0] dat_r, dat_nxt, single_r, single_nxt;
	logic single_pend_r, single_pend_nxt, single_dc_r, single_dc_nxt;
	logic disp_on_r, disp_on_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	logic wr_req, busy;
	logic [31:0] stat_word;
	assign busy = (st_r != opr_pkg::OPR_IDLE);
	assign wr_req = wb_cyc_in && wb_stb_in && wb_we_in && ack_r && wb_sel_in[0];
	assign stat_word = {16'h0000, 6'h00, st_r};
	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		idx_nxt = idx_r;
		rep_nxt = rep_r;
		cur_nxt = cur_r;
		going_up_nxt = going_up_r;
		pump_nxt = pump_r;
		rst_cmd_nxt = rst_cmd_r;
		logic_en_nxt = logic_en_r;
		panel_en_nxt = panel_en_r;
		dcs_nxt = dcs_r;
		cs_n_nxt = cs_n_r;
		wr_n_nxt = wr_n_r;
		dat_nxt = dat_r;
		single_nxt = single_r;
		single_pend_nxt = single_pend_r;
		single_dc_nxt = single_dc_r;
		disp_on_nxt = disp_on_r;
		ack_nxt = wb_cyc_in && wb_stb_in && !ack_r;
		rdat_nxt = 32'h0000_0000;
		if (wb_cyc_in && wb_stb_in && !ack_r && !wb_we_in) begin
			case (wb_adr_in)
				`OPR_ADR_CTRL: rdat_nxt = {28'h0000000, rst_cmd_r, pump_r, 2'b00};
				`OPR_ADR_STAT: rdat_nxt = {stat_word[31:4], disp_on_r, panel_en_r, logic_en_r, busy};
				default: rdat_nxt = 32'h0000_0000;
			endcase
		end
		if (wr_req && wb_adr_in == `OPR_ADR_CTRL) begin
			pump_nxt = wb_dat_in[`OPR_CTRL_PUMP];
			rst_cmd_nxt = wb_dat_in[`OPR_CTRL_RESET];
		end
		case (st_r)
			opr_pkg::OPR_IDLE: begin
				if (wr_req && wb_adr_in == `OPR_ADR_CTRL && wb_dat_in[`OPR_CTRL_UP]) begin
					logic_en_nxt = 1'b1;
					going_up_nxt = 1'b1;
					idx_nxt = 6'd0;
					rep_nxt = 6'd0;
					st_nxt = opr_pkg::OPR_NEXT;
				end else if (wr_req && wb_adr_in == `OPR_ADR_CTRL && wb_dat_in[`OPR_CTRL_DOWN]) begin
					going_up_nxt = 1'b0;
					cur_nxt = {2'b00, `OPR_CMD_DISP_OFF};
					idx_nxt = ROM_LEN[5:0];
					st_nxt = opr_pkg::OPR_SEND;
				end else if (single_pend_r && logic_en_r) begin
					single_pend_nxt = 1'b0;
					cur_nxt = {1'b0, single_dc_r, single_r};
					idx_nxt = ROM_LEN[5:0];
					st_nxt = opr_pkg::OPR_SEND;
				end
				if (wr_req && (wb_adr_in == `OPR_ADR_CMD || wb_adr_in == `OPR_ADR_DEV)) begin
					single_nxt = wb_dat_in[7:0];
					single_dc_nxt = (wb_adr_in == `OPR_ADR_DEV);
					single_pend_nxt = 1'b1;
				end
			end
			opr_pkg::OPR_NEXT: begin
				if (idx_r == ROM_LEN[5:0]) begin
					st_nxt = opr_pkg::OPR_PANEL_ON;
				end else begin
					cur_nxt = rom(idx_r, pump_r);
					st_nxt = opr_pkg::OPR_SEND;
				end
			end
			opr_pkg::OPR_SEND: begin
				dcs_nxt = cur_r[8] | cur_r[9];
				cs_n_nxt = 1'b0;
				wr_n_nxt = 1'b0;
				dat_nxt = cur_r[9] ? 8'h00 : cur_r[7:0];
				st_nxt = opr_pkg::OPR_STROBE;
			end
			opr_pkg::OPR_STROBE: begin
				wr_n_nxt = 1'b1;
				st_nxt = opr_pkg::OPR_RELEASE;
			end
			opr_pkg::OPR_RELEASE: begin
				cs_n_nxt = 1'b1;
				if (cur_r[7:0] == `OPR_CMD_DISP_ON && !cur_r[8]) disp_on_nxt = 1'b1;
				if (cur_r[7:0] == `OPR_CMD_DISP_OFF && !cur_r[8]) disp_on_nxt = 1'b0;
				if (!going_up_r && cur_r == {2'b00, `OPR_CMD_DISP_OFF} && panel_en_r) begin
					st_nxt = opr_pkg::OPR_PANEL_OFF;
				end else if (idx_r == ROM_LEN[5:0]) begin
					st_nxt = opr_pkg::OPR_IDLE;
				end else if (cur_r[9] && rep_r != CLEAR_LEN[5:0]) begin
					rep_nxt = rep_r + 6'd1;
					st_nxt = opr_pkg::OPR_SEND;
				end else begin
					idx_nxt = idx_r + 6'd1;
					rep_nxt = 6'd0;
					st_nxt = opr_pkg::OPR_NEXT;
				end
			end
			opr_pkg::OPR_PANEL_ON: begin
				panel_en_nxt = 1'b1;
				cnt_nxt = 32'h0000_0000;
				st_nxt = opr_pkg::OPR_WAIT_ON;
			end
			opr_pkg::OPR_WAIT_ON: begin
				cnt_nxt = cnt_r + 32'h0000_0001;
				if (cnt_r == SETTLE_CYC - 1) begin
					cur_nxt = {2'b00, `OPR_CMD_DISP_ON};
					idx_nxt = ROM_LEN[5:0];
					st_nxt = opr_pkg::OPR_SEND;
				end
			end
			opr_pkg::OPR_PANEL_OFF: begin
				panel_en_nxt = 1'b0;
				cnt_nxt = 32'h0000_0000;
				st_nxt = opr_pkg::OPR_WAIT_OFF;
			end
			opr_pkg::OPR_WAIT_OFF: begin
				cnt_nxt = cnt_r + 32'h0000_0001;
				if (cnt_r == SETTLE_CYC - 1) st_nxt = opr_pkg::OPR_LOGIC_OFF;
			end
			opr_pkg::OPR_LOGIC_OFF: begin
				if (!panel_en_r) logic_en_nxt = 1'b0;
				st_nxt = opr_pkg::OPR_IDLE;
			end
			default: st_nxt = opr_pkg::OPR_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			st_r <= opr_pkg::OPR_IDLE;
			cnt_r <= 32'h0000_0000;
			idx_r <= 6'h00;
			rep_r <= 6'h00;
			cur_r <= 10'h000;
			going_up_r <= 1'b0;
			pump_r <= 1'b0;
			rst_cmd_r <= 1'b0;
			logic_en_r <= 1'b0;
			panel_en_r <= 1'b0;
			dcs_r <= 1'b0;
			cs_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			dat_r <= 8'h00;
			single_r <= 8'h00;
			single_pend_r <= 1'b0;
			single_dc_r <= 1'b0;
			disp_on_r <= 1'b0;
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			idx_r <= idx_nxt;
			rep_r <= rep_nxt;
			cur_r <= cur_nxt;
			going_up_r <= going_up_nxt;
			pump_r <= pump_nxt;
			rst_cmd_r <= rst_cmd_nxt;
			logic_en_r <= logic_en_nxt;
			panel_en_r <= panel_en_nxt;
			dcs_r <= dcs_nxt;
			cs_n_r <= cs_n_nxt;
			wr_n_r <= wr_n_nxt;
			dat_r <= dat_nxt;
			single_r <= single_nxt;
			single_pend_r <= single_pend_nxt;
			single_dc_r <= single_dc_nxt;
			disp_on_r <= disp_on_nxt;
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end
	assign wb_ack_out = ack_r;
	assign wb_dat_out = rdat_r;
	assign link.panel_reset_n = ~rst_cmd_r;
	assign link.cmd_data_select = dcs_r;
	assign link.cs_n = cs_n_r;
	assign link.wr_n = wr_n_r;
	assign link.data = dat_r;
	assign link.logic_supply_en = logic_en_r;
	assign link.panel_supply_en = panel_en_r;
endmodule

// ==== tb/opr_link_props.sv ====
// link assertions for the panel sequencer
`timescale 1ns/1ps
`include "opr_map.svh"
module opr_link_props #(
	parameter int unsigned SETTLE_CYC = `OPR_SETTLE_CYC
) (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic panel_reset_n,
	input wire logic cmd_data_select,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic [7:0] data,
	input wire logic logic_supply_en,
	input wire logic panel_supply_en
);
	logic wr_q_r, wr_q_nxt, disp_r, disp_nxt, strobe, is_cmd;
	logic [1:0] pend_r, pend_nxt;
	logic [31:0] on_cnt_r, on_cnt_nxt, off_cnt_r, off_cnt_nxt;
	assign strobe = wr_n && !wr_q_r && !cs_n;
	assign is_cmd = strobe && !cmd_data_select;
	////////////////////////////////////////////////////////////////////////////////
	// tracks display state, pending argument and supply ages
	always_comb begin
		wr_q_nxt = wr_n;
		disp_nxt = disp_r;
		pend_nxt = strobe ? 2'h0 : pend_r;
		if (is_cmd && data == `OPR_CMD_DISP_ON) begin
			disp_nxt = 1'b1;
		end
		if (is_cmd && data == `OPR_CMD_DISP_OFF) begin
			disp_nxt = 1'b0;
		end
		if (is_cmd && data == `OPR_CMD_PUMP) begin
			pend_nxt = 2'h1;
		end
		if (is_cmd && data == `OPR_CMD_PRECHG) begin
			pend_nxt = 2'h2;
		end
		on_cnt_nxt = panel_supply_en ? on_cnt_r + 32'h1 : 32'h0;
		off_cnt_nxt = (logic_supply_en && !panel_supply_en) ? off_cnt_r + 32'h1 : 32'h0;
	end
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			wr_q_r <= 1'b1;
			disp_r <= 1'b0;
			pend_r <= 2'h0;
			on_cnt_r <= 32'h0;
			off_cnt_r <= 32'h0;
		end else begin
			wr_q_r <= wr_q_nxt;
			disp_r <= disp_nxt;
			pend_r <= pend_nxt;
			on_cnt_r <= on_cnt_nxt;
			off_cnt_r <= off_cnt_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);
	sequence byte_frame;
		!cs_n ##1 (wr_n && !cs_n) ##1 cs_n;
	endsequence
	chk_logic_holds_panel: assert property (!logic_supply_en |-> !panel_supply_en)
		else $error("panel supply on without logic supply");
	chk_discharge_wait: assert property ($fell(logic_supply_en) |-> off_cnt_r >= SETTLE_CYC - 1)
		else $error("logic supply dropped before discharge time");
	chk_settle_wait: assert property (is_cmd && data == `OPR_CMD_DISP_ON |-> on_cnt_r >= SETTLE_CYC - 1)
		else $error("display on before panel supply settled");
	chk_off_before_drop: assert property ($fell(panel_supply_en) |-> !disp_r)
		else $error("panel supply dropped with display on");
	chk_panel_after_off: assert property ($rose(panel_supply_en) |-> !disp_r)
		else $error("panel supply raised with display on");
	chk_cmd_logic_on: assert property (strobe |-> logic_supply_en)
		else $error("byte sent without logic supply");
	chk_strobe_frame: assert property ($fell(wr_n) |-> byte_frame)
		else $error("byte frame malformed");
	chk_strobe_hold: assert property ($fell(wr_n) |=> $stable(data) && $stable(cmd_data_select))
		else $error("byte changed during strobe");
	chk_pump_arg: assert property (strobe && pend_r == 2'h1 |-> !cmd_data_select && (data == `OPR_ARG_PUMP_ON || data == `OPR_ARG_PUMP_OFF))
		else $error("bad pump argument");
	chk_prechg_arg: assert property (strobe && pend_r == 2'h2 |-> !cmd_data_select && data == `OPR_ARG_PRECHG)
		else $error("bad precharge argument");
endmodule

// ==== tb/tb_oled_power_reset_init_sequencer.sv ====
// self-checking bench with host and panel joined over the link
`timescale 1ns/1ps
`include "opr_map.svh"
module tb_oled_power_reset_init_sequencer;
	localparam int unsigned SETTLE = 50;
	logic ref_clk_in, reset_n_in, cyc, stb, we, ack, pump;
	logic disp_on, pump_on, seg_remap, scan_rev, all_on, mode_128x64;
	logic [3:0] adr, sel;
	logic [31:0] wdat, rdat, rd, panel_word;
	logic [7:0] contrast, column, osc, precharge, data_count, v;
	logic [5:0] start_line;
	logic [2:0] page;
	logic [7:0] cmds [4] = '{`OPR_CMD_ALL_ON, `OPR_CMD_RESUME, `OPR_CMD_SEG_NORM, `OPR_CMD_SCAN_NORM};
	logic [2:0] modes [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
	int failures, comparisons, seed;
	assign panel_word = {2'h0, disp_on, all_on, seg_remap, scan_rev, mode_128x64, page, start_line, column, contrast};
	opr_link_if link();
	opr_host #(.SETTLE_CYC(SETTLE)) i_opr_host (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel), .wb_dat_out(rdat),
		.wb_ack_out(ack), .link(link.host));
	opr_panel i_opr_panel (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .link(link.panel),
		.display_on_out(disp_on), .pump_on_out(pump_on), .contrast_out(contrast), .seg_remap_out(seg_remap),
		.scan_rev_out(scan_rev), .all_on_out(all_on), .column_out(column), .start_line_out(start_line),
		.page_out(page), .mode_128x64_out(mode_128x64), .osc_out(osc), .precharge_out(precharge),
		.data_count_out(data_count));
	opr_link_props #(.SETTLE_CYC(SETTLE)) i_opr_link_props (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
		.panel_reset_n(link.panel_reset_n), .cmd_data_select(link.cmd_data_select), .cs_n(link.cs_n),
		.wr_n(link.wr_n), .data(link.data), .logic_supply_en(link.logic_supply_en),
		.panel_supply_en(link.panel_supply_en));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] reset_word();
		return {2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 6'h00, `OPR_RST_ZERO, `OPR_RST_CONTRAST};
	endfunction
	task automatic complete_run();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge ref_clk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			failures++;
			complete_run();
		end
	endtask
	// polls status until the host is idle, then lets the panel settle
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			wb(1'b0, `OPR_ADR_STAT, 32'h0, 4'hF);
			n++;
		end while (rd[0] !== 1'b0 && n < 500);
		if (rd[0] !== 1'b0) begin
			failures++;
			complete_run();
		end
		repeat (4) @(posedge ref_clk_in);
	endtask
	task automatic send(input logic [3:0] a, input logic [7:0] b);
		wb(1'b1, a, {24'h0, b}, 4'hF);
		wait_idle();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		repeat (100000) @(posedge ref_clk_in);
		failures++;
		complete_run();
	end
	initial begin
		seed = 32'h8f8d;
		failures = 0;
		comparisons = 0;
		reset_n_in = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		wdat = 32'h0;
		sel = 4'h0;
		repeat (3) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		check(panel_word, reset_word());
		wb(1'b0, 4'h2, 32'h0, 4'hF);
		check(rd, 32'h0);
		v = 8'($random(seed));
		pump = v[0];
		wb(1'b1, `OPR_ADR_CTRL, {29'h0, pump, 2'h1}, 4'hF);
		wait_idle();
		check({28'h0, rd[3:0]}, 32'hE);
		check({31'h0, disp_on}, 32'h1);
		check({osc, precharge, data_count, 2'h0, start_line}, {`OPR_ARG_OSC, `OPR_ARG_PRECHG, 8'h31, 8'h00});
		check({28'h0, page, pump_on}, {28'h0, 3'h0, pump});
		check({21'h0, page, column}, {21'h0, 3'h0, 8'h31});
		repeat (4) begin
			v = 8'($random(seed)) & 8'h7F;
			send(`OPR_ADR_CMD, `OPR_CMD_CONTRAST);
			send(`OPR_ADR_CMD, v);
			check({24'h0, contrast}, {24'h0, v});
		end
		for (int i = 0; i < 4; i++) begin
			send(`OPR_ADR_CMD, cmds[i]);
			check({29'h0, all_on, seg_remap, scan_rev}, {29'h0, modes[i]});
		end
		send(`OPR_ADR_CMD, `OPR_CMD_PUMP);
		send(`OPR_ADR_CMD, `OPR_ARG_PUMP_ON);
		check({31'h0, pump_on}, 32'h1);
		send(`OPR_ADR_CMD, `OPR_CMD_PUMP);
		send(`OPR_ADR_CMD, `OPR_ARG_PUMP_OFF);
		check({31'h0, pump_on}, 32'h0);
		wb(1'b1, `OPR_ADR_CTRL, 32'h8, 4'hF);
		repeat (4) @(posedge ref_clk_in);
		check(panel_word, reset_word());
		// without lane 0 the write must be ignored
		wb(1'b1, `OPR_ADR_CTRL, 32'h0, 4'hE);
		wb(1'b0, `OPR_ADR_CTRL, 32'h0, 4'hF);
		check({30'h0, rd[3:2]}, 32'h2);
		wb(1'b1, `OPR_ADR_CTRL, 32'h0, 4'hF);
		wb(1'b1, `OPR_ADR_CTRL, 32'h2, 4'hF);
		wait_idle();
		check({28'h0, rd[3:0]}, 32'h0);
		check({28'h0, link.cs_n, link.wr_n, link.logic_supply_en, link.panel_supply_en}, 32'hC);
		check({31'h0, disp_on}, 32'h0);
		complete_run();
	end
endmodule
